//--- design/tc_cfg_pkg.sv
// Constants for the time-constant and digital configuration register bank.
// Assumes an 8-bit register port with 6-bit addresses driven by the serial front end.
package tc_cfg_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam logic [5:0] FIRST_TC_OFFSET = 6'h02;
    localparam logic [5:0] SECOND_TC_OFFSET = 6'h03;
    localparam logic [5:0] DIG_CONV_OFFSET = 6'h04;
    localparam logic [7:0] FIRST_TC_RESET = 8'h90;
    localparam logic [7:0] SECOND_TC_RESET = 8'ha0;
    localparam logic [7:0] DIG_CONV_RESET = 8'h03;
    // Writable bit masks; reserved bits stay storable but software keeps them zero
    localparam logic [7:0] FIRST_TC_MASK = 8'hff;
    localparam logic [7:0] SECOND_TC_MASK = 8'hff;
    localparam logic [7:0] DIG_CONV_MASK = 8'hff;
    // Field positions
    localparam int CAP_SEL_LSB = 6;
    localparam int FIRST_RES_MSB = 4;
    localparam int FIRST_RSVD_BIT = 5;
    localparam int SECOND_RES_MSB = 5;
    localparam int FREQ_CODE_LSB = 4;
    localparam int DIG_RSVD_BIT = 3;
    localparam int RESP_SEL_MSB = 2;
    // Response period selections
    localparam logic [2:0] RESP_192 = 3'h2;
    localparam logic [2:0] RESP_384 = 3'h3;
    localparam logic [2:0] RESP_3072 = 3'h6;
    localparam logic [2:0] RESP_6144 = 3'h7;
    localparam logic [12:0] PERIODS_192 = 13'h00c0;
    localparam logic [12:0] PERIODS_384 = 13'h0180;
    localparam logic [12:0] PERIODS_3072 = 13'h0c00;
    localparam logic [12:0] PERIODS_6144 = 13'h1800;
endpackage : tc_cfg_pkg

//--- design/cfg_byte_reg.sv
// One 8-bit read/write configuration register with synchronous reset.
// Assumes a single-cycle write strobe from the register port on mclk.
`timescale 1ns/10ps
`default_nettype none
module cfg_byte_reg #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] WR_MASK = 8'hff
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    output logic [7:0] value
);
    logic [7:0] value_reg;
    logic [7:0] value_next;

    assign value_next = wr_en ? ((wr_data & WR_MASK) | (value_reg & ~WR_MASK)) : value_reg;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            value_reg <= RESET_VAL;
        end else begin
            value_reg <= value_next;
        end
    end

    assign value = value_reg;
endmodule : cfg_byte_reg
`default_nettype wire

//--- design/sensor_timeconst_config_regs.sv
// Time-constant and digital conversion configuration register bank.
// Assumes the serial front end presents decoded byte accesses on mclk.
`timescale 1ns/10ps
`default_nettype none
module sensor_timeconst_config_regs
    import tc_cfg_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    output logic [DATA_W-1:0] reg_rdata,
    output logic reg_hit,
    output logic [1:0] first_tc_cap_sel,
    output logic [4:0] first_tc_res_code,
    output logic [1:0] second_tc_cap_sel,
    output logic [5:0] second_tc_res_code,
    output logic [3:0] lowest_sensor_freq_code,
    output logic [2:0] response_period_sel,
    output logic response_sel_valid,
    output logic [12:0] response_periods
);
    ////////////////////////////////////////////////////////////////////////
    wire sel_first = (reg_addr == FIRST_TC_OFFSET);
    wire sel_second = (reg_addr == SECOND_TC_OFFSET);
    wire sel_dig = (reg_addr == DIG_CONV_OFFSET);
    wire [7:0] first_tc_cfg;
    wire [7:0] second_tc_cfg;
    wire [7:0] digital_conversion_cfg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [12:0] periods_next;

    ////////////////////////////////////////////////////////////////////////
    // Writes land in the selected register only
    cfg_byte_reg #(.RESET_VAL(FIRST_TC_RESET), .WR_MASK(FIRST_TC_MASK)) u_first_tc (
        .mclk(mclk), .sys_rst(sys_rst), .wr_en(reg_wr && sel_first),
        .wr_data(reg_wdata), .value(first_tc_cfg));
    cfg_byte_reg #(.RESET_VAL(SECOND_TC_RESET), .WR_MASK(SECOND_TC_MASK)) u_second_tc (
        .mclk(mclk), .sys_rst(sys_rst), .wr_en(reg_wr && sel_second),
        .wr_data(reg_wdata), .value(second_tc_cfg));
    cfg_byte_reg #(.RESET_VAL(DIG_CONV_RESET), .WR_MASK(DIG_CONV_MASK)) u_dig_conv (
        .mclk(mclk), .sys_rst(sys_rst), .wr_en(reg_wr && sel_dig),
        .wr_data(reg_wdata), .value(digital_conversion_cfg));

    ////////////////////////////////////////////////////////////////////////
    // Field taps toward the analog front end and conversion cores
    assign first_tc_cap_sel = first_tc_cfg[CAP_SEL_LSB +: 2];
    assign first_tc_res_code = first_tc_cfg[FIRST_RES_MSB:0];
    assign second_tc_cap_sel = second_tc_cfg[CAP_SEL_LSB +: 2];
    assign second_tc_res_code = second_tc_cfg[SECOND_RES_MSB:0];
    assign lowest_sensor_freq_code = digital_conversion_cfg[FREQ_CODE_LSB +: 4];
    assign response_period_sel = digital_conversion_cfg[RESP_SEL_MSB:0];
    // Reserved and undefined codes leave periods at zero and flag invalid
    assign response_sel_valid = (response_period_sel == RESP_192) || (response_period_sel == RESP_384)
        || (response_period_sel == RESP_3072) || (response_period_sel == RESP_6144);

    always_comb begin
        if (response_period_sel == RESP_192) begin
            periods_next = PERIODS_192;
        end else if (response_period_sel == RESP_384) begin
            periods_next = PERIODS_384;
        end else if (response_period_sel == RESP_3072) begin
            periods_next = PERIODS_3072;
        end else if (response_period_sel == RESP_6144) begin
            periods_next = PERIODS_6144;
        end else begin
            periods_next = 13'h0000;
        end
    end
    assign response_periods = periods_next;

    ////////////////////////////////////////////////////////////////////////
    // Read data registered one cycle after the strobe; unmapped reads give zero
    assign reg_hit = sel_first || sel_second || sel_dig;

    always_comb begin
        if (sel_first) begin
            rdata_next = first_tc_cfg;
        end else if (sel_second) begin
            rdata_next = second_tc_cfg;
        end else if (sel_dig) begin
            rdata_next = digital_conversion_cfg;
        end else begin
            rdata_next = 8'h00;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            rdata_reg <= rdata_next;
        end
    end
    assign reg_rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // Reset checks look one edge after release, once the reset values have landed
    reset_first_a: assert property (@(posedge mclk)
        $past(sys_rst) && !sys_rst |-> first_tc_cfg == FIRST_TC_RESET)
        else $error("first time constant reset wrong");
    reset_second_a: assert property (@(posedge mclk)
        $past(sys_rst) && !sys_rst |-> second_tc_cfg == SECOND_TC_RESET)
        else $error("second time constant reset wrong");
    reset_dig_a: assert property (@(posedge mclk)
        $past(sys_rst) && !sys_rst |-> (response_period_sel == RESP_384 && lowest_sensor_freq_code == 4'h0))
        else $error("digital config reset wrong");
    reset_rsvd_a: assert property (@(posedge mclk)
        $past(sys_rst) && !sys_rst |-> !first_tc_cfg[FIRST_RSVD_BIT] && !digital_conversion_cfg[DIG_RSVD_BIT])
        else $error("reserved bits not cleared by reset");
    reset_rdata_a: assert property (@(posedge mclk)
        $past(sys_rst) && !sys_rst |-> reg_rdata == 8'h00)
        else $error("read data not cleared by reset");

    ////////////////////////////////////////////////////////////////////////
    // Field writes land one edge after the strobe
    first_cap_a: assert property (@(posedge mclk) disable iff (sys_rst)
        reg_wr && sel_first |=> first_tc_cap_sel == $past(reg_wdata[7:6]))
        else $error("first cap select not written");
    first_res_a: assert property (@(posedge mclk) disable iff (sys_rst)
        reg_wr && sel_first |=> first_tc_res_code == $past(reg_wdata[4:0]))
        else $error("first res code not written");
    second_cap_a: assert property (@(posedge mclk) disable iff (sys_rst)
        reg_wr && sel_second |=> second_tc_cap_sel == $past(reg_wdata[7:6]))
        else $error("second cap select not written");
    second_res_a: assert property (@(posedge mclk) disable iff (sys_rst)
        reg_wr && sel_second |=> second_tc_res_code == $past(reg_wdata[5:0]))
        else $error("second res code not written");
    dig_fields_a: assert property (@(posedge mclk) disable iff (sys_rst)
        reg_wr && sel_dig |=> lowest_sensor_freq_code == $past(reg_wdata[7:4])
            && response_period_sel == $past(reg_wdata[2:0]))
        else $error("digital config fields not written");
    // Reset sampled high is kept out of the hold checks, since it rewrites the bank
    first_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !(reg_wr && sel_first) && !sys_rst |=> $stable(first_tc_cfg))
        else $error("first time constant changed without a write");
    second_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !(reg_wr && sel_second) && !sys_rst |=> $stable(second_tc_cfg))
        else $error("second time constant changed without a write");
    dig_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !(reg_wr && sel_dig) && !sys_rst |=> $stable(digital_conversion_cfg))
        else $error("digital config changed without a write");

    // Every bit lands, reserved ones too, since the bank stores them as written
    generate
        for (genvar b = 0; b < DATA_W; b++) begin : g_bit_chk
            first_bit_a: assert property (@(posedge mclk) disable iff (sys_rst)
                reg_wr && sel_first |=> first_tc_cfg[b] == $past(reg_wdata[b]))
                else $error("first register bit not written");
            second_bit_a: assert property (@(posedge mclk) disable iff (sys_rst)
                reg_wr && sel_second |=> second_tc_cfg[b] == $past(reg_wdata[b]))
                else $error("second register bit not written");
            dig_bit_a: assert property (@(posedge mclk) disable iff (sys_rst)
                reg_wr && sel_dig |=> digital_conversion_cfg[b] == $past(reg_wdata[b]))
                else $error("digital register bit not written");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Response decode against the period counts
    // Reserved codes store normally but decode to no period, so nothing runs on them
    resp_192_a: assert property (@(posedge mclk) disable iff (sys_rst)
        response_period_sel == RESP_192 |-> response_periods == 13'h00c0 && response_sel_valid)
        else $error("response period 192 wrong");
    resp_384_a: assert property (@(posedge mclk) disable iff (sys_rst)
        response_period_sel == RESP_384 |-> response_periods == 13'h0180 && response_sel_valid)
        else $error("response period 384 wrong");
    resp_3072_a: assert property (@(posedge mclk) disable iff (sys_rst)
        response_period_sel == RESP_3072 |-> response_periods == 13'h0c00 && response_sel_valid)
        else $error("response period 3072 wrong");
    resp_map_a: assert property (@(posedge mclk) disable iff (sys_rst)
        response_period_sel == RESP_6144 |-> response_periods == 13'h1800 && response_sel_valid)
        else $error("response period map wrong");
    resp_reserved_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !response_period_sel[1] |-> response_periods == 13'h0000 && !response_sel_valid)
        else $error("reserved response code not flagged");
    periods_valid_a: assert property (@(posedge mclk) disable iff (sys_rst)
        response_sel_valid == (response_periods != 13'h0000))
        else $error("response valid flag disagrees with periods");

    ////////////////////////////////////////////////////////////////////////
    // Read port; a read sharing an edge with a write returns the old value
    hit_decode_a: assert property (@(posedge mclk) disable iff (sys_rst)
        reg_hit == (reg_addr >= FIRST_TC_OFFSET && reg_addr <= DIG_CONV_OFFSET))
        else $error("register hit decode wrong");
    read_first_a: assert property (@(posedge mclk) disable iff (sys_rst)
        reg_rd && sel_first |=> reg_rdata == $past(first_tc_cfg))
        else $error("first time constant read wrong");
    read_second_a: assert property (@(posedge mclk) disable iff (sys_rst)
        reg_rd && sel_second |=> reg_rdata == $past(second_tc_cfg))
        else $error("second time constant read wrong");
    read_dig_a: assert property (@(posedge mclk) disable iff (sys_rst)
        reg_rd && sel_dig |=> reg_rdata == $past(digital_conversion_cfg))
        else $error("digital config read wrong");
    unmapped_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
        reg_rd && !reg_hit |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !reg_rd && !sys_rst |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    // Back-to-back write then read is the fastest sequence the host may issue
    readback_a: assert property (@(posedge mclk) disable iff (sys_rst)
        reg_wr && sel_dig ##1 reg_rd && sel_dig && !reg_wr |=> reg_rdata == $past(reg_wdata, 2))
        else $error("readback mismatch");

endmodule : sensor_timeconst_config_regs
`default_nettype wire

//--- verification/reg_host.sv
// Host model: byte writes and reads on the register port.
// Assumes one mclk domain; strobes change just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module reg_host
    import tc_cfg_pkg::*;
(
    input wire logic mclk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [ADDR_W-1:0] reg_addr,
    output logic [DATA_W-1:0] reg_wdata,
    input wire logic [DATA_W-1:0] reg_rdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 6'h3f;
        reg_wdata = 8'h00;
    end
    ////////////////////////////////////////////////////////////
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= (a == FIRST_TC_OFFSET) ? d & 8'hdf : (a == DIG_CONV_OFFSET) ? d & 8'hf7 : d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        // Stale data inverted so nothing can lean on it
        reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
    task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        q = reg_rdata;
    endtask : wr_rd
endmodule : reg_host
`default_nettype wire

//--- verification/tb.sv
// Testbench: reset values, field readback, response decode, unmapped access.
// Assumes reg_host drives the port; mclk 100 MHz.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import tc_cfg_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr, reg_rd, reg_hit, valid;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, rd_val, v;
    logic [1:0] cap1, cap2;
    logic [4:0] res1;
    logic [5:0] res2;
    logic [3:0] freq;
    logic [2:0] resp;
    logic [12:0] periods;
    int num_errors = 0;
    int total_checks = 0;
    always #5 mclk = ~mclk;
    reg_host host(.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata));
    sensor_timeconst_config_regs dut(.mclk(mclk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
        .first_tc_cap_sel(cap1), .first_tc_res_code(res1), .second_tc_cap_sel(cap2), .second_tc_res_code(res2),
        .lowest_sensor_freq_code(freq), .response_period_sel(resp), .response_sel_valid(valid),
        .response_periods(periods));
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    task automatic rchk(input logic [5:0] a, input logic [7:0] exp, input logic hit);
        host.rd(a, rd_val);
        check({reg_hit, rd_val}, {hit, exp});
    endtask : rchk
    task automatic defaults();
        rchk(FIRST_TC_OFFSET, 8'h90, 1'b1);
        rchk(SECOND_TC_OFFSET, 8'ha0, 1'b1);
        rchk(DIG_CONV_OFFSET, 8'h03, 1'b1);
        check({cap1, res1, cap2, res2}, 16'h50a0);
        check({freq, resp, valid}, 16'h0007);
        check(periods, 16'h0180);
    endtask : defaults
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        defaults();
        for (int j = 0; j < 2; j++) begin
            v = j ? 8'h00 : 8'hff;
            host.wr(FIRST_TC_OFFSET, v & 8'hdf);
            host.wr(SECOND_TC_OFFSET, v);
            host.wr(DIG_CONV_OFFSET, v & 8'hf7);
            #1;
            check({cap1, 1'b0, res1}, v & 8'hdf);
            check({cap2, res2}, v);
            check({freq, 1'b0, resp}, v & 8'hf7);
            rchk(FIRST_TC_OFFSET, v & 8'hdf, 1'b1);
            rchk(SECOND_TC_OFFSET, v, 1'b1);
            rchk(DIG_CONV_OFFSET, v & 8'hf7, 1'b1);
        end
        for (int c = 0; c < 8; c++) begin
            host.wr(DIG_CONV_OFFSET, {5'h00, c[2:0]});
            #1;
            check({resp, valid}, {c[2:0], c[1]});
            check(periods, c[1] ? 16'h00c0 << (c[0] + 4 * c[2]) : 16'h0000);
        end
        // Lowest sensor frequency 1 MHz gives code 16 - 8 = 8; read straight after the write
        host.wr_rd(DIG_CONV_OFFSET, 8'h83, rd_val);
        check(rd_val, 8'h83);
        check({freq, resp}, 16'h0043);
        // Neighbours of the bank must neither answer nor disturb it
        host.wr(6'h05, 8'h55);
        host.wr(6'h01, 8'haa);
        rchk(6'h05, 8'h00, 1'b0);
        rchk(6'h01, 8'h00, 1'b0);
        rchk(DIG_CONV_OFFSET, 8'h83, 1'b1);
        @(posedge mclk);
        sys_rst <= 1'b1;
        @(posedge mclk);
        sys_rst <= 1'b0;
        #1;
        check(reg_rdata, 8'h00);
        defaults();
        end_of_test();
    end
    // Whole run is well under a few hundred cycles
    initial begin
        #50000;
        num_errors++;
        end_of_test();
    end
endmodule : tb
`default_nettype wire
